// >>> pkg/odc_params.svh
`ifndef ODC_PARAMS_SVH
`define ODC_PARAMS_SVH

// ----------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------
`define ODC_ADDR_DAC_PWR    7'h25
`define ODC_ADDR_HP_DRV     7'h26

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ODC_BIT_LEFT_DAC    7
`define ODC_BIT_RIGHT_DAC   6
`define ODC_LCOM_HI         5
`define ODC_LCOM_LO         4
`define ODC_RCOM_HI         5
`define ODC_RCOM_LO         3
`define ODC_BIT_SCP_EN      2
`define ODC_BIT_SCP_MODE    1

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define ODC_LCOM_DIFF       2'h0
`define ODC_LCOM_CM         2'h1
`define ODC_LCOM_SE         2'h2
`define ODC_LCOM_RSVD       2'h3
`define ODC_RCOM_DIFF       3'h0
`define ODC_RCOM_CM         3'h1
`define ODC_RCOM_SE         3'h2
`define ODC_RCOM_DIFF_LEFT  3'h3
`define ODC_RCOM_EXT_FB     3'h4
`define ODC_RCOM_LAST_LEGAL 3'h4

// ----------------------------------------------------------------
// Reset values and fixed read values
// ----------------------------------------------------------------
`define ODC_RST_BIT         1'h0
`define ODC_RST_LCOM        2'h0
`define ODC_RST_RCOM        3'h0
`define ODC_RST_BYTE        8'h00
`define ODC_RSVD_LOW4       4'h0
`define ODC_RSVD_TOP2       2'h0
`define ODC_RSVD_BIT        1'h0
`define ODC_ADDR_W_MIN      7

`endif

// >>> pkg/odc_pkg.sv
package odc_pkg;

    // Common output roles, one-hot
    typedef enum logic [4:0] {
        odc_role_diff_main = 5'h01,
        odc_role_common    = 5'h02,
        odc_role_single    = 5'h04,
        odc_role_diff_left = 5'h08,
        odc_role_ext_fb    = 5'h10
    } odc_role_type;

    typedef struct packed {
        odc_role_type left_hp_common_output_role;
        odc_role_type right_hp_common_output_role;
        logic         scp_current_limit;
        logic         scp_auto_power_down;
    } odc_drv_cfg_type;

endpackage : odc_pkg

// >>> verilog/odc_role_decode.sv
`timescale 1ns/1ns
`include "odc_params.svh"

module odc_role_decode (
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire logic [1:0]                left_com_field,
    input  wire logic [2:0]                right_com_field,
    input  wire logic                      scp_enable,
    input  wire logic                      scp_mode,
    output      odc_pkg::odc_drv_cfg_type  drv_cfg
);
    import odc_pkg::*;

    odc_drv_cfg_type next_drv_cfg;

    // ----------------------------------------------------------------
    // Role and protection decode
    // ----------------------------------------------------------------
    always_comb begin
        next_drv_cfg = '0;
        // External feedback forces left common to common-mode level
        if (right_com_field == `ODC_RCOM_EXT_FB) begin
            next_drv_cfg.left_hp_common_output_role = odc_role_common;
        end else begin
            unique case (left_com_field)
                `ODC_LCOM_DIFF: next_drv_cfg.left_hp_common_output_role = odc_role_diff_main;
                `ODC_LCOM_CM:   next_drv_cfg.left_hp_common_output_role = odc_role_common;
                `ODC_LCOM_SE:   next_drv_cfg.left_hp_common_output_role = odc_role_single;
                default:        next_drv_cfg.left_hp_common_output_role = odc_role_diff_main;
            endcase
        end
        unique case (right_com_field)
            `ODC_RCOM_DIFF:      next_drv_cfg.right_hp_common_output_role = odc_role_diff_main;
            `ODC_RCOM_CM:        next_drv_cfg.right_hp_common_output_role = odc_role_common;
            `ODC_RCOM_SE:        next_drv_cfg.right_hp_common_output_role = odc_role_single;
            `ODC_RCOM_DIFF_LEFT: next_drv_cfg.right_hp_common_output_role = odc_role_diff_left;
            `ODC_RCOM_EXT_FB:    next_drv_cfg.right_hp_common_output_role = odc_role_ext_fb;
            default:             next_drv_cfg.right_hp_common_output_role = odc_role_diff_main;
        endcase
        next_drv_cfg.scp_current_limit   = scp_enable & ~scp_mode;
        next_drv_cfg.scp_auto_power_down = scp_enable & scp_mode;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            drv_cfg <= '{odc_role_diff_main, odc_role_diff_main,
                         `ODC_RST_BIT, `ODC_RST_BIT};
        end else begin
            drv_cfg <= next_drv_cfg;
        end
    end

endmodule : odc_role_decode

// >>> verilog/odc_regs.sv
`timescale 1ns/1ns
`include "odc_params.svh"

// How it works
// - D6 of DAC power register powers right DAC
// - Left common field picks its output role unless right code is external feedback
// - Reserved bits read zero, write zeros
// - Right common field picks its output role
// - Code 011 left-differential, 100 external feedback
// - D2 enables short protection on all drivers
// - D1 picks current limit or auto power-down
// - D0 of driver register reserved, reads zero
// - D7 of DAC power register powers left DAC
module odc_regs #(
    parameter int ADDR_W = 7
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [ADDR_W-1:0]         reg_addr,
    input  wire logic [7:0]                reg_wdata,
    output      logic [7:0]                reg_rdata,
    output      logic                      reg_rd_valid,
    output      logic                      left_dac_power_up,
    output      logic                      right_dac_power_up,
    output      odc_pkg::odc_drv_cfg_type  drv_cfg
);
    import odc_pkg::*;

    if (ADDR_W < `ODC_ADDR_W_MIN) begin : g_addr_w_check
        $error("ADDR_W too small for register numbers");
    end

    localparam logic [ADDR_W-1:0] ADDR_DAC_PWR = ADDR_W'(`ODC_ADDR_DAC_PWR);
    localparam logic [ADDR_W-1:0] ADDR_HP_DRV  = ADDR_W'(`ODC_ADDR_HP_DRV);

    logic [1:0] left_com_field;
    logic [2:0] right_com_field;
    logic       scp_enable;
    logic       scp_mode;
    logic       wr_dac_pwr;
    logic       wr_hp_drv;
    logic [1:0] wr_lcom;
    logic [2:0] wr_rcom;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] want);
        return a == want;
    endfunction : addr_hit

    assign wr_dac_pwr = reg_wr & addr_hit(reg_addr, ADDR_DAC_PWR);
    assign wr_hp_drv  = reg_wr & addr_hit(reg_addr, ADDR_HP_DRV);
    assign wr_lcom    = reg_wdata[`ODC_LCOM_HI:`ODC_LCOM_LO];
    assign wr_rcom    = reg_wdata[`ODC_RCOM_HI:`ODC_RCOM_LO];

    // ----------------------------------------------------------------
    // DAC power and left common field
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            left_dac_power_up  <= `ODC_RST_BIT;
            right_dac_power_up <= `ODC_RST_BIT;
        end else if (wr_dac_pwr) begin
            left_dac_power_up  <= reg_wdata[`ODC_BIT_LEFT_DAC];
            right_dac_power_up <= reg_wdata[`ODC_BIT_RIGHT_DAC];
        end
    end

    // Reserved code is dropped so the field never holds it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            left_com_field <= `ODC_RST_LCOM;
        end else if (wr_dac_pwr && wr_lcom != `ODC_LCOM_RSVD) begin
            left_com_field <= wr_lcom;
        end
    end

    // ----------------------------------------------------------------
    // High-power driver fields
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            right_com_field <= `ODC_RST_RCOM;
        end else if (wr_hp_drv && wr_rcom <= `ODC_RCOM_LAST_LEGAL) begin
            right_com_field <= wr_rcom;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            scp_enable <= `ODC_RST_BIT;
            scp_mode   <= `ODC_RST_BIT;
        end else if (wr_hp_drv) begin
            scp_enable <= reg_wdata[`ODC_BIT_SCP_EN];
            scp_mode   <= reg_wdata[`ODC_BIT_SCP_MODE];
        end
    end

    // ----------------------------------------------------------------
    // Read-back
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= `ODC_RST_BYTE;
        end else if (reg_rd) begin
            if (addr_hit(reg_addr, ADDR_DAC_PWR)) begin
                reg_rdata <= {left_dac_power_up, right_dac_power_up, left_com_field,
                              `ODC_RSVD_LOW4};
            end else if (addr_hit(reg_addr, ADDR_HP_DRV)) begin
                reg_rdata <= {`ODC_RSVD_TOP2, right_com_field, scp_enable, scp_mode,
                              `ODC_RSVD_BIT};
            end else begin
                reg_rdata <= `ODC_RST_BYTE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rd_valid <= `ODC_RST_BIT;
        end else begin
            reg_rd_valid <= reg_rd;
        end
    end

    // ----------------------------------------------------------------
    // Driver configuration decode
    // ----------------------------------------------------------------
    odc_role_decode u_decode (
        .core_clk        (core_clk),
        .rst_b           (rst_b),
        .left_com_field  (left_com_field),
        .right_com_field (right_com_field),
        .scp_enable      (scp_enable),
        .scp_mode        (scp_mode),
        .drv_cfg         (drv_cfg)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_right_dac;
        wr_dac_pwr |=> right_dac_power_up == $past(reg_wdata[`ODC_BIT_RIGHT_DAC]);
    endproperty
    a_right_dac: assert property (p_right_dac) else $error("right DAC power wrong");

    property p_left_dac;
        wr_dac_pwr |=> left_dac_power_up == $past(reg_wdata[`ODC_BIT_LEFT_DAC]);
    endproperty
    a_left_dac: assert property (p_left_dac) else $error("left DAC power wrong");

    property p_left_role;
        wr_dac_pwr && wr_lcom == `ODC_LCOM_SE && right_com_field != `ODC_RCOM_EXT_FB
            && !wr_hp_drv
        |=> ##1 drv_cfg.left_hp_common_output_role == odc_role_single;
    endproperty
    a_left_role: assert property (p_left_role) else $error("left role not single");

    property p_left_rsvd;
        wr_dac_pwr && wr_lcom == `ODC_LCOM_RSVD |=> $stable(left_com_field);
    endproperty
    a_left_rsvd: assert property (p_left_rsvd) else $error("reserved left code stored");

    property p_rsvd_read;
        reg_rd && addr_hit(reg_addr, ADDR_DAC_PWR)
        |=> reg_rd_valid && reg_rdata[3:0] == `ODC_RSVD_LOW4;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits not zero");

    property p_hp_rsvd_read;
        reg_rd && addr_hit(reg_addr, ADDR_HP_DRV) |=> reg_rdata[7:6] == `ODC_RSVD_TOP2
            && reg_rdata[0] == `ODC_RSVD_BIT;
    endproperty
    a_hp_rsvd_read: assert property (p_hp_rsvd_read) else $error("reserved bits set");

    property p_right_cm;
        right_com_field == `ODC_RCOM_CM
        |=> drv_cfg.right_hp_common_output_role == odc_role_common;
    endproperty
    a_right_cm: assert property (p_right_cm) else $error("right role not common");

    property p_ext_fb;
        right_com_field == `ODC_RCOM_EXT_FB |=> drv_cfg.right_hp_common_output_role
            == odc_role_ext_fb && drv_cfg.left_hp_common_output_role == odc_role_common;
    endproperty
    a_ext_fb: assert property (p_ext_fb) else $error("external feedback roles wrong");

    property p_right_diff_left;
        right_com_field == `ODC_RCOM_DIFF_LEFT
        |=> drv_cfg.right_hp_common_output_role == odc_role_diff_left;
    endproperty
    a_right_diff_left: assert property (p_right_diff_left) else $error("right role wrong");

    property p_right_rsvd;
        wr_hp_drv && wr_rcom > `ODC_RCOM_LAST_LEGAL |=> $stable(right_com_field);
    endproperty
    a_right_rsvd: assert property (p_right_rsvd) else $error("reserved right code stored");

    property p_scp_off;
        !scp_enable |=> !drv_cfg.scp_current_limit && !drv_cfg.scp_auto_power_down;
    endproperty
    a_scp_off: assert property (p_scp_off) else $error("protection active while off");

    property p_scp_mode;
        scp_enable |=> drv_cfg.scp_auto_power_down == $past(scp_mode)
            && drv_cfg.scp_current_limit == !$past(scp_mode);
    endproperty
    a_scp_mode: assert property (p_scp_mode) else $error("protection mode wrong");

    c_ext_fb: cover property (wr_hp_drv && wr_rcom == `ODC_RCOM_EXT_FB ##2
                              drv_cfg.right_hp_common_output_role == odc_role_ext_fb);
    c_powerdown: cover property (drv_cfg.scp_auto_power_down);
    c_both_dacs: cover property (left_dac_power_up && right_dac_power_up);
    c_read_back: cover property (reg_rd_valid && reg_rdata != `ODC_RST_BYTE);
    c_left_drop: cover property (wr_dac_pwr && wr_lcom == `ODC_LCOM_RSVD);

endmodule : odc_regs

// >>> bench/odc_regs_tb.sv
`timescale 1ns/1ns
`include "odc_params.svh"

module testbench;
    import odc_pkg::*;

    logic            core_clk;
    logic            rst_b;
    logic            reg_wr;
    logic            reg_rd;
    logic [6:0]      reg_addr;
    logic [7:0]      reg_wdata;
    logic [7:0]      reg_rdata;
    logic            reg_rd_valid;
    logic            left_dac_power_up;
    logic            right_dac_power_up;
    odc_drv_cfg_type drv_cfg;
    int              bad_count;
    int              n_checks;

    odc_regs #(
        .ADDR_W             (7)
    ) dut (
        .core_clk           (core_clk),
        .rst_b              (rst_b),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_rdata          (reg_rdata),
        .reg_rd_valid       (reg_rd_valid),
        .left_dac_power_up  (left_dac_power_up),
        .right_dac_power_up (right_dac_power_up),
        .drv_cfg            (drv_cfg)
    );

    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        #20000;
        bad_count++;
        $display("[FAIL] %0t ns: run did not finish in time", $time);
        results();
    end

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // Strobe held for one cycle; returns 1 ns after the taking edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'h1;
        tick(1);
        reg_wr    = 1'h0;
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd   = 1'h1;
        tick(1);
        reg_rd   = 1'h0;
        chk({15'h0000, reg_rd_valid}, 16'h0001);
        chk({8'h00, reg_rdata}, {8'h00, exp});
        tick(1);
        chk({15'h0000, reg_rd_valid}, 16'h0000);
    endtask : rd

    // Role outputs settle one cycle after the write edge
    task automatic cfg(input logic [4:0] lr, input logic [4:0] rr, input logic lim,
                       input logic apd);
        tick(1);
        chk({4'h0, drv_cfg}, {4'h0, lr, rr, lim, apd});
    endtask : cfg

    task automatic dacs(input logic l, input logic r);
        chk({14'h0000, left_dac_power_up, right_dac_power_up}, {14'h0000, l, r});
    endtask : dacs

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        bad_count = 0;
        n_checks  = 0;
        rst_b     = 1'h0;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_addr  = 7'h00;
        reg_wdata = 8'h00;
        repeat (10) @(posedge core_clk);
        #1;
        rst_b = 1'h1;
        dacs(1'h0, 1'h0);
        chk({4'h0, drv_cfg}, 16'h0084);
        rd(`ODC_ADDR_DAC_PWR, 8'h00);
        rd(`ODC_ADDR_HP_DRV, 8'h00);
        // Left common roles, reserved low bits written as ones
        for (int c = 0; c < 3; c++) begin
            wr(`ODC_ADDR_DAC_PWR, 8'(c << 4) | 8'h0F);
            cfg(5'(1 << c), 5'h01, 1'h0, 1'h0);
            rd(`ODC_ADDR_DAC_PWR, 8'(c << 4));
        end
        // Reserved left code dropped, DAC bits still taken
        wr(`ODC_ADDR_DAC_PWR, 8'hFF);
        dacs(1'h1, 1'h1);
        cfg(5'h04, 5'h01, 1'h0, 1'h0);
        rd(`ODC_ADDR_DAC_PWR, 8'hE0);
        wr(`ODC_ADDR_DAC_PWR, 8'h40);
        dacs(1'h0, 1'h1);
        rd(`ODC_ADDR_DAC_PWR, 8'h40);
        // Right common roles, external feedback forces left to common mode
        for (int c = 0; c < 5; c++) begin
            wr(`ODC_ADDR_HP_DRV, 8'(c << 3));
            cfg((c == 4) ? 5'h02 : 5'h01, 5'(1 << c), 1'h0, 1'h0);
            rd(`ODC_ADDR_HP_DRV, 8'(c << 3));
        end
        // Reserved right code dropped, protection bits still taken
        wr(`ODC_ADDR_HP_DRV, 8'hFF);
        cfg(5'h02, 5'h10, 1'h0, 1'h1);
        rd(`ODC_ADDR_HP_DRV, 8'h26);
        wr(`ODC_ADDR_HP_DRV, 8'h04);
        cfg(5'h01, 5'h01, 1'h1, 1'h0);
        wr(`ODC_ADDR_HP_DRV, 8'h02);
        cfg(5'h01, 5'h01, 1'h0, 1'h0);
        // Unmapped register, then a mapped read after one idle cycle
        wr(7'h27, 8'hFF);
        rd(7'h27, 8'h00);
        rd(`ODC_ADDR_HP_DRV, 8'h02);
        // Reset in mid-run clears all fields
        wr(`ODC_ADDR_DAC_PWR, 8'hD0);
        rst_b = 1'h0;
        tick(1);
        rst_b = 1'h1;
        dacs(1'h0, 1'h0);
        chk({4'h0, drv_cfg}, 16'h0084);
        rd(`ODC_ADDR_DAC_PWR, 8'h00);
        results();
    end

endmodule : testbench
